// ---- verilog/adc_channel_select_serial.sv ----
// Purpose: digital control of a two-input 10-bit serial converter
// Assumes: host frames with chip select low and supplies whole 16-clock conversions
// Notes:   link logic runs on the serial clock, core side on sys_clk_i
// How it works
// - control bits 7,6,2,1,0 have no effect
// - bit 3 chooses input for next conversion, bits 5 and 4 are dropped
// - bit3 low picks first input, high second
// - result is 10-bit unsigned straight binary
// - powered while chip select low apart from the gaps between conversions, down otherwise
// - power down from 16th fall to next 1st
// - each conversion is 16 clocks, back to back
// - conversions repeat while chip select stays low
// - data output driven only while chip select low
// - control word taken on first 8 rising edges
// - track three clocks, result msb first from fourth
`timescale 1ns/10ps
`default_nettype none
module adc_channel_select_serial
  import adc_sel_pkg::*;
(
  input  wire logic                        sys_clk_i,    // core clock, 250 MHz
  input  wire logic                        rst_i,        // synchronous reset, active high
  input  wire logic [adc_sel_pkg::RESULT_W-1:0] conv_code_i, // code from the analog core
  output var  logic                        chan_b_sel_o, // mux select, high = second input
  output var  logic                        powered_o,    // analog core powered
  output var  logic                        tracking_o,   // track phase under way
  output var  logic [adc_sel_pkg::RESULT_W-1:0] result_o, // last code captured
  input  wire logic                        sclk_i,       // serial clock from the host
  input  wire logic                        cs_n_i,       // chip select, active low
  input  wire logic                        din_i,        // serial control data in
  output var  logic                        dout_o,       // serial result data out
  output var  logic                        dout_oe_o     // output enable of dout_o
);
  import adc_sel_pkg::*;

  // rising-edge detection between a synchronised level and its last value
  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction : rose

  // ---------------- link side, rising edges ----------------
  logic [3:0] rcnt;                // rising edges seen in this conversion, mod 16
  logic [6:0] ctrl_shift;          // control bits gathered so far
  logic       chan_hold;           // address captured at the 8th rising edge
  logic       req_lvl;             // asks the core side for a code, rises 3 to 9
  logic       addr_lvl;            // new address ready, rises 8 to 16
  logic [3:0] next_rcnt;
  logic [6:0] next_ctrl_shift;
  logic       next_chan_hold;
  logic       next_req_lvl;
  logic       next_addr_lvl;
  logic [CTRL_W-1:0] ctrl_word;    // full control word at the 8th rising edge

  // next values on each rising serial clock edge
  always_comb begin
    ctrl_word       = {ctrl_shift, din_i};
    next_rcnt       = rcnt + 4'h1;
    next_ctrl_shift = ctrl_shift;
    next_chan_hold  = chan_hold;
    next_req_lvl    = req_lvl;
    next_addr_lvl   = addr_lvl;
    if (rcnt < CTRL_LAST) begin
      next_ctrl_shift = {ctrl_shift[5:0], din_i};
    end else if (rcnt == CTRL_LAST) begin
      // bit 3 decides input; bits 5 and 4 are dropped, bit 4 high is the host's fault
      next_chan_hold = ctrl_word[ADDR_BIT_LO];
      next_addr_lvl  = 1'b1;
    end
    if (rcnt == ADDR_CLR_CNT) begin
      next_addr_lvl = 1'b0;
    end
    // request window is wide so the core side sees it whatever the phase
    if (rcnt == REQ_SET_CNT) begin
      next_req_lvl = 1'b1;
    end else if (rcnt == REQ_CLR_CNT) begin
      next_req_lvl = 1'b0;
    end
  end

  // chip select high gates the link logic off and restarts the conversion count;
  // the request levels clear low so no false event reaches the core side
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      rcnt       <= 4'h0;
      ctrl_shift <= 7'h00;
      chan_hold  <= CHAN_A;
      req_lvl    <= 1'b0;
      addr_lvl   <= 1'b0;
    end else begin
      rcnt       <= next_rcnt;
      ctrl_shift <= next_ctrl_shift;
      chan_hold  <= next_chan_hold;
      req_lvl    <= next_req_lvl;
      addr_lvl   <= next_addr_lvl;
    end
  end

  // ---------------- link side, falling edges ----------------
  logic [3:0] fcnt;                // falling edges seen in this conversion, mod 16
  logic [RESULT_W-2:0] out_shift;  // result bits still to send
  logic       pwr_lvl;             // low only in the gap between conversions
  logic       trk_lvl;             // high during the three track clocks
  logic [3:0] next_fcnt;
  logic [RESULT_W-2:0] next_out_shift;
  logic       next_dout;
  logic       next_pwr_lvl;
  logic       next_trk_lvl;

  // next values on each falling serial clock edge
  always_comb begin
    next_fcnt      = fcnt + 4'h1;
    next_out_shift = out_shift;
    next_dout      = 1'b0;
    next_pwr_lvl   = (next_fcnt != CONV_WRAP);
    next_trk_lvl   = (next_fcnt != CONV_WRAP) && (next_fcnt <= TRACK_LAST);
    if (next_fcnt == MSB_FALL) begin
      // msb from fourth clock
      // result_o was loaded a few core clocks after the 3rd rising edge and is steady here
      next_dout      = result_o[RESULT_W-1];
      next_out_shift = result_o[RESULT_W-2:0];
    end else if ((next_fcnt > MSB_FALL) && (next_fcnt <= LSB_FALL)) begin
      next_dout      = out_shift[RESULT_W-2];
      next_out_shift = {out_shift[RESULT_W-3:0], 1'b0};
    end
  end

  // falling-edge registers, cleared while the frame is closed, except pwr_lvl which is set high
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      fcnt      <= 4'h0;
      out_shift <= '0;
      dout_o    <= 1'b0;
      pwr_lvl   <= 1'b1;
      trk_lvl   <= 1'b0;
    end else begin
      fcnt      <= next_fcnt;
      out_shift <= next_out_shift;
      dout_o    <= next_dout;
      pwr_lvl   <= next_pwr_lvl;
      trk_lvl   <= next_trk_lvl;
    end
  end

  assign dout_oe_o = ~cs_n_i;

  // ---------------- crossings into the core clock ----------------
  logic cs_n_s;                    // chip select, synchronised
  logic pwr_s;                     // power level, synchronised
  logic trk_s;                     // track level, synchronised
  logic req_s;                     // code request, synchronised
  logic addr_s;                    // address ready, synchronised

  sync_level #(.RESET_VAL(CS_IDLE_N)) u_sync_cs (
    .clk_i(sys_clk_i), .rst_i(rst_i), .async_i(cs_n_i), .sync_o(cs_n_s));
  sync_level #(.RESET_VAL(1'b1)) u_sync_pwr (
    .clk_i(sys_clk_i), .rst_i(rst_i), .async_i(pwr_lvl), .sync_o(pwr_s));
  sync_level #(.RESET_VAL(1'b0)) u_sync_trk (
    .clk_i(sys_clk_i), .rst_i(rst_i), .async_i(trk_lvl), .sync_o(trk_s));
  sync_level #(.RESET_VAL(1'b0)) u_sync_req (
    .clk_i(sys_clk_i), .rst_i(rst_i), .async_i(req_lvl), .sync_o(req_s));
  sync_level #(.RESET_VAL(1'b0)) u_sync_addr (
    .clk_i(sys_clk_i), .rst_i(rst_i), .async_i(addr_lvl), .sync_o(addr_s));

  // ---------------- core side ----------------
  logic req_d;                     // last synchronised request
  logic addr_d;                    // last synchronised address flag
  logic next_req_d;
  logic next_addr_d;
  logic next_chan_b_sel;
  logic next_powered;
  logic next_tracking;
  logic [RESULT_W-1:0] next_result;

  // next core-side values
  always_comb begin
    next_req_d      = req_s;
    next_addr_d     = addr_s;
    next_chan_b_sel = chan_b_sel_o;
    next_result     = result_o;
    if (rose(req_s, req_d)) begin
      next_result = conv_code_i;
    end
    // chan_hold is steady from the 8th rising edge on, so it is safe to take here
    if (rose(addr_s, addr_d)) begin
      next_chan_b_sel = chan_hold;
    end
    next_powered  = ~cs_n_s & pwr_s;
    next_tracking = ~cs_n_s & trk_s;
  end

  // core-side registers; the first input is selected after reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_d        <= 1'b0;
      addr_d       <= 1'b0;
      chan_b_sel_o <= CHAN_A;
      result_o     <= '0;
      powered_o    <= 1'b0;
      tracking_o   <= 1'b0;
    end else begin
      req_d        <= next_req_d;
      addr_d       <= next_addr_d;
      chan_b_sel_o <= next_chan_b_sel;
      result_o     <= next_result;
      powered_o    <= next_powered;
      tracking_o   <= next_tracking;
    end
  end
endmodule : adc_channel_select_serial
`default_nettype wire

// ---- verilog/adc_sel_pkg.sv ----
// Purpose: shared constants for the two-input serial converter control block
// Assumes: 16 link clocks per conversion, 8-bit control word, 10-bit result
// Notes:   link-side counts are 4-bit wrap-around counters
package adc_sel_pkg;
  localparam int          RESULT_W      = 10;      // result width, straight binary
  localparam int          CTRL_W        = 8;       // control word width
  localparam int          CODE_STEPS    = 1024;    // equal code steps over full range
  localparam int          ADDR_BIT_LO   = 3;       // channel address bit that picks the input
  localparam int          ADDR_BIT_MID  = 4;       // must stay zero (host duty)
  localparam int          ADDR_BIT_HI   = 5;       // ignored address bit
  localparam logic [3:0]  CTRL_LAST     = 4'h7;    // rise count before the 8th rising edge
  localparam logic [3:0]  REQ_SET_CNT   = 4'h2;    // rise count before the 3rd rising edge
  localparam logic [3:0]  REQ_CLR_CNT   = 4'h8;    // rise count before the 9th rising edge
  localparam logic [3:0]  ADDR_CLR_CNT  = 4'hf;    // rise count before the 16th rising edge
  localparam logic [3:0]  TRACK_LAST    = 4'h3;    // last falling edge of the track phase
  localparam logic [3:0]  MSB_FALL      = 4'h4;    // falling edge that puts out the msb
  localparam logic [3:0]  LSB_FALL      = 4'hd;    // falling edge that puts out the lsb
  localparam logic [3:0]  CONV_WRAP     = 4'h0;    // 16th edge, counter wraps to zero
  localparam logic        CHAN_A        = 1'b0;    // first input, the default
  localparam logic        CHAN_B        = 1'b1;    // second input
  localparam logic        CS_IDLE_N     = 1'b1;    // chip select level outside frames
endpackage : adc_sel_pkg

// ---- verilog/sync_level.sv ----
// Purpose: two-flop synchroniser for one level into the system clock
// Assumes: input level stays put for several destination clocks
// Notes:   only the second flop is visible outside
`timescale 1ns/10ps
`default_nettype none
module sync_level #(
  parameter logic RESET_VAL = 1'b0            // value both flops take in reset
) (
  input  wire logic clk_i,                    // destination clock
  input  wire logic rst_i,                    // synchronous reset, active high
  input  wire logic async_i,                  // level from the other domain
  output var  logic sync_o                    // synchronised level
);
  logic meta;                                 // first stage, read only by the second
  logic next_meta;                            // next first stage
  logic next_sync;                            // next second stage

  // next values of both stages
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  // register both stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule : sync_level
`default_nettype wire

// ---- bench/adc_sel_sva.sv ----
// Purpose: concurrent checks on the converter control ports
// Assumes: sclk idles high between frames
// Notes:   rise_cnt restarts whenever chip select is high
`timescale 1ns/10ps
`default_nettype none
module adc_sel_sva (
  input wire logic                            sys_clk_i,
  input wire logic                            rst_i,
  input wire logic                            chan_b_sel_o,
  input wire logic                            powered_o,
  input wire logic                            tracking_o,
  input wire logic [adc_sel_pkg::RESULT_W-1:0] result_o,
  input wire logic                            sclk_i,
  input wire logic                            cs_n_i,
  input wire logic                            dout_o,
  input wire logic                            dout_oe_o
);
  logic [3:0] rise_cnt;       // rises already seen in this conversion
  logic [3:0] next_rise_cnt;  // wraps after 16, as conversions run back to back
  always_comb next_rise_cnt = rise_cnt + 4'h1;
  // chip select high clears it, so an aborted conversion restarts at zero
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) rise_cnt <= 4'h0;
    else rise_cnt <= next_rise_cnt;
  end
  oe_follows_cs_a: assert property (@(posedge sys_clk_i) dout_oe_o == !cs_n_i)
    else $error("dout enable does not follow chip select");
  cs_power_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(cs_n_i) |-> ##[1:5] !powered_o) else $error("power stays on after deselect");
  lead_zeros_a: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    rise_cnt < 4'h3 |-> !dout_o) else $error("dout not zero in track phase");
  tail_zeros_a: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    rise_cnt > 4'hc |-> !dout_o) else $error("dout not zero after lsb");
  result_bits_a: assert property (@(posedge sclk_i) disable iff (cs_n_i)
    rise_cnt inside {[4'h3:4'hc]} |-> dout_o == result_o[4'hc - rise_cnt])
    else $error("dout bit differs from result");
  sel_in_frame_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(chan_b_sel_o) |-> !cs_n_i) else $error("channel changed outside a frame");
  result_in_frame_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $changed(result_o) |-> !cs_n_i && powered_o) else $error("result taken while idle");
  track_power_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tracking_o |-> powered_o) else $error("tracking while powered down");
  cover property (@(posedge sclk_i) rise_cnt == 4'hf);
  cover property (@(posedge sys_clk_i) $rose(chan_b_sel_o));
  cover property (@(posedge sys_clk_i) $fell(powered_o) && !cs_n_i);
endmodule : adc_sel_sva
bind adc_channel_select_serial adc_sel_sva u_adc_sel_sva (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .chan_b_sel_o(chan_b_sel_o), .powered_o(powered_o),
  .tracking_o(tracking_o), .result_o(result_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .dout_o(dout_o), .dout_oe_o(dout_oe_o));
`default_nettype wire

// ---- bench/adc_host_model.sv ----
// Purpose: host serial port that frames conversions
// Assumes: sclk idles high, period 64 ns
// Notes:   din toggles after the control word and as a frame closes
`timescale 1ns/10ps
`default_nettype none
module adc_host_model (
  output var  logic sclk_o,     // serial clock
  output var  logic cs_n_o,     // chip select, active low
  output var  logic din_o,      // control data
  input  wire logic dout_i,     // result data
  input  wire logic dout_oe_i   // result driver enable
);
  wire logic dout_line = dout_oe_i ? dout_i : 1'bz;  // released line floats
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic frame_edge(input logic open);
    #32 cs_n_o = ~open;
    if (!open) din_o = ~din_o;
  endtask : frame_edge
  // msb first, bit4 low, no gaps
  task automatic conv(input logic [7:0] ctrl, input int nclk, output logic [9:0] got);
    logic [7:0] word;
    word = ctrl & 8'hef;
    got = 10'h000;
    for (int i = 0; i < nclk; i++) begin
      #32 sclk_o = 1'b0;
      din_o = (i < 8) ? word[7 - i] : ~din_o;
      #32 sclk_o = 1'b1;
      if (i >= 3 && i <= 12) got = {got[8:0], dout_line};
    end
  endtask : conv
endmodule : adc_host_model
`default_nettype wire

// ---- bench/adc_channel_select_serial_tb_top.sv ----
// Purpose: self-checking bench for the converter control block
// Assumes: host model sends whole 16-clock conversions, apart from one aborted after 5 clocks
// Notes:   expected codes and channels come from the stimulus tables in scn_stream, and from literals in scn_abort
`timescale 1ns/10ps
`default_nettype none
module adc_channel_select_serial_tb_top;
  import adc_sel_pkg::*;
  logic       sys_clk_i;               // core clock, 4 ns
  logic       rst_i;                   // core reset
  logic [9:0] conv_code_i;             // code offered by the analog core
  logic       chan_b_sel_o, powered_o, tracking_o, sclk_i, cs_n_i, din_i, dout_o, dout_oe_o;
  logic [9:0] result_o;
  int         error_cnt = 0;
  int         total_checks = 0;
  always #2 sys_clk_i = ~sys_clk_i;
  adc_channel_select_serial u_adc_channel_select_serial (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .conv_code_i(conv_code_i), .chan_b_sel_o(chan_b_sel_o), .powered_o(powered_o),
    .tracking_o(tracking_o), .result_o(result_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
    .din_i(din_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o));
  adc_host_model u_adc_host_model (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i),
    .dout_i(dout_o), .dout_oe_i(dout_oe_o));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // inputs move 1 ns after a core edge
  task automatic sys_wait(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : sys_wait
  // four conversions in one frame, ignored bits set, boundary codes
  task automatic scn_stream;
    logic [7:0] ctrl [4] = '{8'h08, 8'he7, 8'hef, 8'h00};
    logic [9:0] code [4] = '{10'h3ff, 10'h000, 10'h2a5, 10'h15a};
    logic [9:0] got;
    check(chan_b_sel_o, CHAN_A);
    u_adc_host_model.frame_edge(1'b1);
    for (int k = 0; k < 4; k++) begin
      sys_wait(1);
      conv_code_i = code[k];
      u_adc_host_model.conv(ctrl[k], 16, got);
      check(got, code[k]);
      check(result_o, code[k]);
      check(chan_b_sel_o, ctrl[k][3]);
    end
    u_adc_host_model.frame_edge(1'b0);
  endtask : scn_stream
  // power, tracking and output enable around one conversion
  task automatic scn_power;
    logic [9:0] got;
    u_adc_host_model.frame_edge(1'b1);
    sys_wait(2);
    check(dout_oe_o, 1'b1);
    fork
      u_adc_host_model.conv(8'h00, 16, got);
      begin
        sys_wait(20);
        check(powered_o, 1'b1);
        check(tracking_o, 1'b1);
        sys_wait(50);
        check(tracking_o, 1'b0);
      end
    join
    sys_wait(4);
    check(powered_o, 1'b0);
    u_adc_host_model.frame_edge(1'b0);
    sys_wait(8);
    check(powered_o, 1'b0);
    check(dout_oe_o, 1'b0);
  endtask : scn_power
  // aborted conversion, then a full one, then a second reset
  task automatic scn_abort;
    logic [9:0] got;
    u_adc_host_model.frame_edge(1'b1);
    u_adc_host_model.conv(8'h08, 5, got);
    u_adc_host_model.frame_edge(1'b0);
    sys_wait(4);
    check(chan_b_sel_o, CHAN_A);
    u_adc_host_model.frame_edge(1'b1);
    u_adc_host_model.conv(8'h08, 16, got);
    u_adc_host_model.frame_edge(1'b0);
    check(chan_b_sel_o, CHAN_B);
    // second reset lands just after a core edge, like every other core input
    sys_wait(1);
    rst_i = 1'b1;
    sys_wait(2);
    rst_i = 1'b0;
    check(chan_b_sel_o, CHAN_A);
    sys_wait(2);
    check(chan_b_sel_o, CHAN_A);
    check(result_o, 10'h000);
    check(powered_o, 1'b0);
    // a full conversion after the second reset still carries its code
    conv_code_i = 10'h1c3;
    u_adc_host_model.frame_edge(1'b1);
    u_adc_host_model.conv(8'h00, 16, got);
    u_adc_host_model.frame_edge(1'b0);
    check(got, 10'h1c3);
    check(result_o, 10'h1c3);
    check(chan_b_sel_o, CHAN_A);
  endtask : scn_abort
  initial begin
    sys_clk_i   = 1'b0;
    rst_i       = 1'b1;
    conv_code_i = 10'h000;
    sys_wait(2);
    rst_i = 1'b0;
    sys_wait(4);
    scn_stream();
    scn_power();
    scn_abort();
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    error_cnt++;
    report_and_stop();
  end
endmodule : adc_channel_select_serial_tb_top
`default_nettype wire
